/* File: rtl/pixel_output_bus_formatter.sv */
// Pixel output bus formatter: two-entry skid buffer feeding even and odd buses.
// Assumes the pixel source is synchronous to CLK; mode pins are asynchronous straps.
`timescale 1ns/1ps
module pixel_output_bus_formatter
  import pixel_out_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             RESETN,
  input  wire logic             CE,
  input  wire logic [PIX_W-1:0] PIX_DATA,
  input  wire logic             PIX_LINE_START,
  input  wire logic             PIX_VALID,
  output logic                  PIX_READY,
  input  wire logic             PIXELS_PER_CLOCK_SELECT,
  input  wire logic             OUTPUT_EDGE_SELECT,
  input  wire logic             STAGGER_SELECT_N,
  output logic                  OUTPUT_DATA_CLOCK,
  output logic [PIX_W-1:0]      EVEN_PIXEL_BUS,
  output logic [PIX_W-1:0]      ODD_PIXEL_BUS,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);

  typedef struct packed {
    logic [1:0]       sel_s1;
    logic [1:0]       sel_s2;
    logic [1:0]       stg_s;
    logic [PIX_W-1:0] buf0;
    logic             sol0;
    logic [PIX_W-1:0] buf1;
    logic             sol1;
    logic [1:0]       cnt;
    logic             phase;
    logic             rclk;
    logic [PIX_W-1:0] even_q;
    logic [PIX_W-1:0] odd_q;
    logic [PIX_W-1:0] odd_hold;
    logic             vld_q;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   two_px;
  logic   stagger;
  logic   pop;
  logic   advance;

  // Keeps byte lanes explicit on the buses
  function automatic logic [PIX_W-1:0] lanes(input logic [PIX_W-1:0] p);
    logic [PIX_W-1:0] r;
    r = PIX_ZERO;
    r[BLUE_LSB  +: LANE_W] = p[BLUE_LSB  +: LANE_W];
    r[GREEN_LSB +: LANE_W] = p[GREEN_LSB +: LANE_W];
    r[RED_LSB   +: LANE_W] = p[RED_LSB   +: LANE_W];
    return r;
  endfunction

  // Output register may take a new word
  function automatic logic slot_free(input logic vld, input logic rdy);
    return !vld || rdy;
  endfunction

  assign two_px  = s_q.sel_s2[0];
  assign stagger = two_px & ~s_q.stg_s[1];
  assign advance = slot_free(s_q.vld_q, OUT_READY);
  // Full at two entries; an upstream stall then waits, nothing is lost
  assign PIX_READY = (s_q.cnt != CNT_FULL);

  always_comb begin
    s_d = s_q;
    s_d.sel_s1 = {OUTPUT_EDGE_SELECT, PIXELS_PER_CLOCK_SELECT};
    s_d.sel_s2 = s_q.sel_s1;
    s_d.stg_s  = {s_q.stg_s[0], STAGGER_SELECT_N};
    pop = 1'b0;
    // Two-pixel mode waits for a pair; line start realigns so pixel zero is even
    if (advance) begin
      if (two_px) begin
        if (s_q.cnt == CNT_FULL && !s_q.sol1) begin
          s_d.even_q = lanes(s_q.buf0);
          s_d.odd_hold = lanes(s_q.buf1);
          s_d.vld_q = 1'b1;
          pop = 1'b1;
        end else begin
          s_d.vld_q = 1'b0;
        end
      end else begin
        if (s_q.cnt != CNT_ZERO) begin
          s_d.even_q = lanes(s_q.buf0);
          s_d.odd_hold = PIX_ZERO;
          s_d.vld_q = 1'b1;
        end else begin
          s_d.vld_q = 1'b0;
        end
      end
    end
    // Stagger delays odd bus by one CLK to spread switching current
    if (!two_px) begin
      s_d.odd_q = PIX_ZERO;
    end else if (!stagger) begin
      s_d.odd_q = s_d.odd_hold;
    end else begin
      s_d.odd_q = s_q.odd_hold;
    end
    // One toggle per word; a pair counts as one word
    if (s_d.vld_q && advance) begin
      s_d.rclk = ~s_q.rclk;
    end
    s_d.phase = s_q.rclk;
    // Buffer bookkeeping: pop one or two, then push
    begin
      logic [1:0] n;
      n = s_q.cnt;
      if (advance && !two_px && s_q.cnt != CNT_ZERO) begin
        s_d.buf0 = s_q.buf1;
        s_d.sol0 = s_q.sol1;
        n = n - CNT_ONE;
      end else if (pop) begin
        n = CNT_ZERO;
      end else if (two_px && s_q.cnt == CNT_FULL && s_q.sol1) begin
        // Even pixel orphaned by a new line: drop it, restart the pair
        s_d.buf0 = s_q.buf1;
        s_d.sol0 = s_q.sol1;
        n = CNT_ONE;
      end
      if (PIX_VALID && PIX_READY) begin
        if (n == CNT_ZERO) begin
          s_d.buf0 = PIX_DATA;
          s_d.sol0 = PIX_LINE_START;
        end else begin
          s_d.buf1 = PIX_DATA;
          s_d.sol1 = PIX_LINE_START;
        end
        n = n + CNT_ONE;
      end
      s_d.cnt = n;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // edge select inverts the clock so data launches on the chosen edge
  assign OUTPUT_DATA_CLOCK = s_q.rclk ^ ~s_q.sel_s2[1];
  // Straps are synchronised twice, so mode changes lag the pins
  assign EVEN_PIXEL_BUS    = s_q.even_q;
  assign ODD_PIXEL_BUS     = s_q.odd_q;
  assign OUT_VALID         = s_q.vld_q;

endmodule // pixel_output_bus_formatter

/* File: rtl/pixel_out_pkg.sv */
// Constants for the pixel output bus formatter.
// Assumes a single 25 MHz system clock and an upstream decoded-pixel stream.
// Operation
// - Blue on even bus bits 0 to 7
// - Green on even bus bits 8 to 15
// - Red on even bus bits 16 to 23
// - Two-pixel mode: even pixel on even bus
// - Two-pixel mode: odd pixel on odd bus
// - One-pixel mode: odd bus held low
// - Buses update with output data clock; stagger low moves the odd bus one CLK later
// - Select high two pixels, low one pixel
// - One-pixel mode sends even pixel first
// - Edge select picks rising or falling launch
// - Stagger low offsets even and odd buses
package pixel_out_pkg;
  localparam int BLUE_LSB  = 0;
  localparam int GREEN_LSB = 8;
  localparam int RED_LSB   = 16;
  localparam int LANE_W    = 8;
  localparam int PIX_W     = 24;
  localparam logic [PIX_W-1:0] PIX_ZERO = 24'h00_0000;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE  = 2'h1;
  localparam logic [1:0] CNT_FULL = 2'h2;
endpackage

/* File: testbench/pob_chk.sv */
// Port checker for the pixel output bus formatter.
// Assumes straps are steady while words flow.
`timescale 1ns/1ps
module pob_chk
  import pixel_out_pkg::*;
(
  input wire logic             CLK,
  input wire logic             RESETN,
  input wire logic             PIXELS_PER_CLOCK_SELECT,
  input wire logic             STAGGER_SELECT_N,
  input wire logic             OUTPUT_DATA_CLOCK,
  input wire logic [PIX_W-1:0] EVEN_PIXEL_BUS,
  input wire logic [PIX_W-1:0] ODD_PIXEL_BUS,
  input wire logic             OUT_VALID,
  input wire logic             OUT_READY
);
  wire p = PIXELS_PER_CLOCK_SELECT, s = STAGGER_SELECT_N, v = OUT_VALID, r = OUT_READY;
  wire [PIX_W-1:0] e = EVEN_PIXEL_BUS, o = ODD_PIXEL_BUS;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_odd; !p[*4] ##0 v |-> o == 0; endproperty
  a_odd: assert property (p_odd) else $error("odd bus set");
  property p_clk; $changed(e) |-> $changed(OUTPUT_DATA_CLOCK); endproperty
  a_clk: assert property (p_clk) else $error("no clock edge");
  property p_hold; v && !r |=> v && $stable(e); endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_fell; $fell(v) |-> $past(r); endproperty
  a_fell: assert property (p_fell) else $error("valid dropped");
  property p_new; $changed(e) |-> v; endproperty
  a_new: assert property (p_new) else $error("bus moved idle");
  property p_sim; (p && s)[*4] ##0 $changed(o) |-> $changed(e); endproperty
  a_sim: assert property (p_sim) else $error("not together");
  property p_stg; (p && !s)[*4] ##0 $changed(e) |=> $changed(o); endproperty
  a_stg: assert property (p_stg) else $error("no stagger");
  property p_pair; (p && s)[*4] ##0 v |-> o != e; endproperty
  a_pair: assert property (p_pair) else $error("pair copy");
endmodule // pob_chk
bind pixel_output_bus_formatter pob_chk chk (.*);

/* File: testbench/panel_rx.sv */
// Panel receiver model: collects words, stalls on request.
// Assumes straps fixed while words flow.
`timescale 1ns/1ps
module panel_rx (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        pair,
  input  wire logic        stagger_select_n_n,
  input  wire logic        vld,
  input  wire logic [23:0] ev,
  input  wire logic [23:0] od,
  output logic             rdy = 1'b1
);
  logic        late_q = 1'b0;
  logic [23:0] got[$];
  wire         take = vld && rdy;
  // Late odd pushed first so pair order survives back-to-back words
  always @(posedge clk) begin
    if (late_q) got.push_back(od);
    if (take) got.push_back(ev);
    if (take && pair && stagger_select_n_n) got.push_back(od);
    late_q <= take && pair && !stagger_select_n_n;
    rdy <= #1 stall ? !rdy : 1'b1;
  end
endmodule // panel_rx

/* File: testbench/pixel_output_bus_formatter_tb.sv */
// Bench for the pixel output bus formatter.
// Assumes pob_chk binds itself and panel_rx collects words.
`timescale 1ns/1ps
module pixel_output_bus_formatter_tb;
  import pixel_out_pkg::*;
  logic clk = 0, rstn = 0, vld = 0, ls = 0, p2 = 0, es = 1, sn = 1, stall = 1, old;
  logic [PIX_W-1:0] pd = PIX_ZERO;
  wire  [PIX_W-1:0] eb, ob;
  wire              rdy, output_data_clock, ov, ordy;
  int               fail_count = 0, cmp_count = 0;
  always #20 clk = ~clk;
  pixel_output_bus_formatter dut (.CLK(clk), .RESETN(rstn), .CE(1'b1), .PIX_DATA(pd),
    .PIX_LINE_START(ls), .PIX_VALID(vld), .PIX_READY(rdy), .PIXELS_PER_CLOCK_SELECT(p2),
    .OUTPUT_EDGE_SELECT(es), .STAGGER_SELECT_N(sn), .OUTPUT_DATA_CLOCK(output_data_clock),
    .EVEN_PIXEL_BUS(eb), .ODD_PIXEL_BUS(ob), .OUT_VALID(ov), .OUT_READY(ordy));
  panel_rx rx (.clk(clk), .stall(stall), .pair(p2), .stagger_select_n_n(sn), .vld(ov), .ev(eb),
    .od(ob), .rdy(ordy));
  task automatic cmp(input logic [PIX_W-1:0] g, x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // Pixel 0 flagged as line start; n even in two-pixel mode
  task automatic run(input int n, input logic [PIX_W-1:0] b);
    for (int i = 0; i < n; i++) begin
      pd = b + 24'h01_0101 * 24'(i);
      ls = i == 0;
      vld = 1;
      while (!rdy) @(posedge clk) #1;
      @(posedge clk) #1;
    end
    vld = 0;
    for (int k = 0; k < 60 && rx.got.size() < n; k++) @(posedge clk) #1;
    for (int i = 0; i < n; i++) cmp(rx.got.pop_front(), b + 24'h01_0101 * 24'(i));
  endtask
  task automatic t_one();
    old = output_data_clock;
    run(5, 24'h30_2010);
    cmp(ob, PIX_ZERO);
    cmp({23'h0, output_data_clock}, {23'h0, ~old});
    $display("one-pixel done");
  endtask
  task automatic t_two();
    {p2, stall} = 2'b10;
    repeat (4) @(posedge clk) #1;
    run(4, 24'h60_5040);
    $display("two-pixel done");
  endtask
  task automatic t_stagger_select_n();
    sn = 0;
    run(4, 24'h90_8070);
    $display("stagger done");
  endtask
  task automatic t_edge();
    old = output_data_clock;
    es = 0;
    repeat (5) @(posedge clk) #1;
    cmp({23'h0, output_data_clock}, {23'h0, ~old});
    $display("edge done");
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    repeat (3) @(posedge clk) #1;
    t_one();
    t_two();
    t_stagger_select_n();
    t_edge();
    end_sim();
  end
  initial begin
    #40000;
    fail_count++;
    end_sim();
  end
endmodule // pixel_output_bus_formatter_tb
